//--- hw/teic_top.sv
// What this block does
// (R1) writing a compare buffer sets that channel's buffer-valid flag
// (R2) an update condition clears every compare buffer-valid flag
// (R3) period buffer write sets its valid flag; update clears it
// (R4) event control: input B action in bits 7:5, B enable bit 4
// (R5) B code 0 does nothing; codes 1, 2 and 7 are reserved
// (R6) B direction code keeps counting clocks or events as input A selects
// (R7) B direction code: count up while event low, down while high
// (R8) B code 4 restarts the counter on each rising event edge
// (R9) B code 5 restarts the counter on every event edge
// (R10) B code 6 holds the counter in restart while event high
// (R11) B enable low: input B ignored whatever the code
// (R12) B enable high: input B acts as its code says
// (R13) A codes: rise count, any-edge count, count while high, direction
// (R14) input A acts only when its enable bit is set
// (R15) update lock set: buffers are not copied on update
// (R16) event restart behaves like the software restart command
`timescale 1ns/1ps
`default_nettype none
module teic_top #(
    parameter int ADDR_W = 12,
    parameter int NUM_CMP = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_a,
    input wire logic event_b,
    input wire logic presc_tick,
    output logic [15:0] count_value,
    output logic [15:0] period_value,
    output logic [NUM_CMP*16-1:0] compare_value,
    output logic count_dir,
    output logic restart_pulse,
    output logic update_pulse
);
    initial begin
        if (ADDR_W < 11 || ADDR_W > 32) begin
            $error("teic_top: ADDR_W out of range");
        end
        if (NUM_CMP < 1 || NUM_CMP > 4) begin
            $error("teic_top: NUM_CMP out of range");
        end
    end

    // bus decode
    logic [7:0] idx;
    logic hi_zero;
    logic wr_en;
    logic rd_setup;
    logic hit;
    logic [31:0] rd_val;

    assign idx = paddr[9:2];
    assign hi_zero = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
    assign wr_en = psel & penable & pwrite & hit;
    assign rd_setup = psel & ~penable;
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // configuration registers
    logic [7:0] event_ctrl_r;
    logic [7:0] event_ctrl_nxt;
    logic lock_r;
    logic lock_nxt;
    logic sw_upd;
    logic sw_rst;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    assign sw_upd = wr_en && idx == teic_pkg::IDX_CTRL && pwdata[teic_pkg::CTRL_UPD_POS];
    assign sw_rst = wr_en && idx == teic_pkg::IDX_CTRL && pwdata[teic_pkg::CTRL_RST_POS];

    always_comb begin
        event_ctrl_nxt = event_ctrl_r;
        lock_nxt = lock_r;
        prdata_nxt = prdata_r;
        if (wr_en && idx == teic_pkg::IDX_EVENT_CTRL) begin
            event_ctrl_nxt = pwdata[7:0]; // R4
        end
        if (wr_en && idx == teic_pkg::IDX_CTRL) begin
            lock_nxt = pwdata[teic_pkg::CTRL_LOCK_POS];
        end
        if (rd_setup) begin
            prdata_nxt = rd_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_ctrl_r <= teic_pkg::EVENT_CTRL_RST;
            lock_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            event_ctrl_r <= event_ctrl_nxt;
            lock_r <= lock_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    // event channel decode
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;

    teic_evsense u_sense_a (
        .pclk(pclk),
        .presetn(presetn),
        .ev_in(event_a),
        .rise(a_rise),
        .fall(a_fall)
    );

    teic_evsense u_sense_b (
        .pclk(pclk),
        .presetn(presetn),
        .ev_in(event_b),
        .rise(b_rise),
        .fall(b_fall)
    );

    teic_pkg::teic_acta_t act_a;
    teic_pkg::teic_actb_t act_b;
    logic a_on;
    logic b_on;
    logic step_a;
    logic count_step;
    logic dir_now;
    logic ev_restart;
    logic restart_now;

    assign act_a = teic_pkg::teic_acta_t'(event_ctrl_r[teic_pkg::EV_A_ACT_POS +: teic_pkg::ACT_W]);
    assign act_b = teic_pkg::teic_actb_t'(event_ctrl_r[teic_pkg::EV_B_ACT_POS +: teic_pkg::ACT_W]);
    assign a_on = event_ctrl_r[teic_pkg::EV_A_ENA_POS]; // R14
    assign b_on = event_ctrl_r[teic_pkg::EV_B_ENA_POS]; // R11

    always_comb begin
        // reserved input A codes fall back to plain prescaled counting
        unique case (act_a)
            teic_pkg::ACTA_COUNT_RISE: step_a = a_rise; // R13
            teic_pkg::ACTA_COUNT_ANY: step_a = a_rise | a_fall; // R13
            teic_pkg::ACTA_COUNT_HIGH: step_a = presc_tick & event_a; // R13
            teic_pkg::ACTA_DIRECTION: step_a = presc_tick; // R13
            default: step_a = presc_tick;
        endcase
    end

    // input B never gates the step, so its direction code keeps A's counting
    assign count_step = a_on ? step_a : presc_tick; // R6

    always_comb begin
        dir_now = 1'b0;
        if (a_on && act_a == teic_pkg::ACTA_DIRECTION) begin
            dir_now = event_a; // R13
        end
        if (b_on && act_b == teic_pkg::ACTB_DIRECTION) begin
            dir_now = event_b; // R7
        end
    end

    always_comb begin
        ev_restart = 1'b0;
        if (b_on) begin // R12
            unique case (act_b)
                teic_pkg::ACTB_RESTART_RISE: ev_restart = b_rise; // R8
                teic_pkg::ACTB_RESTART_EITHER: ev_restart = b_rise | b_fall; // R9
                teic_pkg::ACTB_RESTART_HIGH: ev_restart = event_b; // R10
                default: ev_restart = 1'b0; // R5
            endcase
        end
    end

    assign restart_now = ev_restart | sw_rst; // R16

    // counter and working period
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] per_r;
    logic [15:0] per_nxt;
    logic [15:0] per_buf_r;
    logic [15:0] per_buf_nxt;
    logic per_valid_r;
    logic per_valid_nxt;
    logic dir_r;
    logic rst_out_r;
    logic upd_out_r;
    logic wrap;
    logic apply_upd;
    logic per_buf_wr;

    assign per_buf_wr = wr_en && idx == teic_pkg::IDX_PER_BUFFER;

    always_comb begin
        cnt_nxt = cnt_r;
        wrap = 1'b0;
        if (restart_now) begin
            cnt_nxt = dir_now ? per_r : teic_pkg::CNT_RST; // R16
        end else if (count_step) begin
            if (!dir_now) begin
                wrap = (cnt_r == per_r);
                cnt_nxt = wrap ? 16'h0000 : cnt_r + 16'h0001;
            end else begin
                wrap = (cnt_r == 16'h0000);
                cnt_nxt = wrap ? per_r : cnt_r - 16'h0001;
            end
        end
        // bus write takes priority over counting
        if (wr_en && idx == teic_pkg::IDX_CNT) begin
            cnt_nxt = pwdata[15:0];
        end
    end

    // lock also keeps the valid flags, so software sees what is pending
    assign apply_upd = (wrap | sw_upd) & ~lock_r; // R15

    always_comb begin
        per_nxt = per_r;
        per_buf_nxt = per_buf_r;
        per_valid_nxt = per_valid_r;
        if (apply_upd) begin
            per_nxt = per_valid_r ? per_buf_r : per_r;
            per_valid_nxt = 1'b0; // R3
        end
        if (per_buf_wr) begin
            per_buf_nxt = pwdata[15:0];
            per_valid_nxt = 1'b1; // R3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= teic_pkg::CNT_RST;
            per_r <= teic_pkg::PER_RST;
            per_buf_r <= teic_pkg::PER_RST;
            per_valid_r <= 1'b0;
            dir_r <= 1'b0;
            rst_out_r <= 1'b0;
            upd_out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            per_buf_r <= per_buf_nxt;
            per_valid_r <= per_valid_nxt;
            dir_r <= dir_now;
            rst_out_r <= restart_now;
            upd_out_r <= apply_upd;
        end
    end

    assign count_value = cnt_r;
    assign period_value = per_r;
    assign count_dir = dir_r;
    assign restart_pulse = rst_out_r;
    assign update_pulse = upd_out_r;

    // compare channels
    logic [15:0] cmpbuf_q [NUM_CMP];
    logic [15:0] cmp_q [NUM_CMP];
    logic [NUM_CMP-1:0] cmpbv_q;

    for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
        logic [15:0] buf_r;
        logic [15:0] buf_nxt;
        logic [15:0] cmp_r;
        logic [15:0] cmp_nxt;
        logic bv_r;
        logic bv_nxt;
        logic buf_wr;

        assign buf_wr = wr_en && idx == teic_pkg::IDX_CMPBUF0 + 8'(g * 2);

        always_comb begin
            buf_nxt = buf_r;
            cmp_nxt = cmp_r;
            bv_nxt = bv_r;
            if (apply_upd) begin
                cmp_nxt = bv_r ? buf_r : cmp_r;
                bv_nxt = 1'b0; // R2
            end
            // a write in the update cycle stays pending
            if (buf_wr) begin
                buf_nxt = pwdata[15:0];
                bv_nxt = 1'b1; // R1
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                buf_r <= teic_pkg::CMP_RST;
                cmp_r <= teic_pkg::CMP_RST;
                bv_r <= 1'b0;
            end else begin
                buf_r <= buf_nxt;
                cmp_r <= cmp_nxt;
                bv_r <= bv_nxt;
            end
        end

        assign cmpbuf_q[g] = buf_r;
        assign cmp_q[g] = cmp_r;
        assign cmpbv_q[g] = bv_r;
        assign compare_value[g*16 +: 16] = cmp_r;
    end

    // read mux and address map
    always_comb begin
        rd_val = 32'h0000_0000;
        hit = 1'b0;
        if (hi_zero) begin
            unique case (idx)
                teic_pkg::IDX_CTRL: begin
                    hit = 1'b1;
                    rd_val[teic_pkg::CTRL_LOCK_POS] = lock_r;
                end
                teic_pkg::IDX_FLAGS: begin
                    hit = 1'b1;
                    rd_val[teic_pkg::FLAG_PER_POS] = per_valid_r;
                    rd_val[teic_pkg::FLAG_CMP_POS +: NUM_CMP] = cmpbv_q;
                end
                teic_pkg::IDX_EVENT_CTRL: begin
                    hit = 1'b1;
                    rd_val[7:0] = event_ctrl_r;
                end
                teic_pkg::IDX_STATUS: begin
                    hit = 1'b1;
                    rd_val[teic_pkg::STAT_DIR_POS] = dir_r;
                    rd_val[teic_pkg::STAT_RST_POS] = rst_out_r;
                end
                teic_pkg::IDX_CNT: begin
                    hit = 1'b1;
                    rd_val[15:0] = cnt_r;
                end
                teic_pkg::IDX_PER: begin
                    hit = 1'b1;
                    rd_val[15:0] = per_r;
                end
                teic_pkg::IDX_PER_BUFFER: begin
                    hit = 1'b1;
                    rd_val[15:0] = per_buf_r;
                end
                default: begin
                    for (int i = 0; i < NUM_CMP; i++) begin
                        if (idx == teic_pkg::IDX_CMP0 + 8'(i * 2)) begin
                            hit = 1'b1;
                            rd_val[15:0] = cmp_q[i];
                        end
                        if (idx == teic_pkg::IDX_CMPBUF0 + 8'(i * 2)) begin
                            hit = 1'b1;
                            rd_val[15:0] = cmpbuf_q[i];
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- hw/teic_pkg.sv
package teic_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h04;
    localparam logic [7:0] IDX_FLAGS = 8'h07;
    localparam logic [7:0] IDX_EVENT_CTRL = 8'h09;
    localparam logic [7:0] IDX_STATUS = 8'h0C;
    localparam logic [7:0] IDX_CNT = 8'h20;
    localparam logic [7:0] IDX_PER = 8'h26;
    localparam logic [7:0] IDX_CMP0 = 8'h28;
    localparam logic [7:0] IDX_PER_BUFFER = 8'h36;
    localparam logic [7:0] IDX_CMPBUF0 = 8'h38;
    localparam logic [7:0] IDX_CH_STEP = 8'h02;

    // event_input_control fields
    localparam int EV_A_ENA_POS = 0;
    localparam int EV_A_ACT_POS = 1;
    localparam int EV_B_ENA_POS = 4;
    localparam int EV_B_ACT_POS = 5;
    localparam int ACT_W = 3;

    // control register fields
    localparam int CTRL_LOCK_POS = 0;
    localparam int CTRL_UPD_POS = 1;
    localparam int CTRL_RST_POS = 2;

    // status register fields
    localparam int STAT_DIR_POS = 0;
    localparam int STAT_RST_POS = 1;

    // flags register: period valid at bit 0, compare n at bit n+1
    localparam int FLAG_PER_POS = 0;
    localparam int FLAG_CMP_POS = 1;

    localparam logic [7:0] EVENT_CTRL_RST = 8'h00;
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;

    typedef enum logic [2:0] {
        ACTA_COUNT_RISE = 3'h0,
        ACTA_COUNT_ANY = 3'h1,
        ACTA_COUNT_HIGH = 3'h2,
        ACTA_DIRECTION = 3'h3
    } teic_acta_t;

    typedef enum logic [2:0] {
        ACTB_NONE = 3'h0,
        ACTB_RES1 = 3'h1,
        ACTB_RES2 = 3'h2,
        ACTB_DIRECTION = 3'h3,
        ACTB_RESTART_RISE = 3'h4,
        ACTB_RESTART_EITHER = 3'h5,
        ACTB_RESTART_HIGH = 3'h6,
        ACTB_RES7 = 3'h7
    } teic_actb_t;
endpackage

//--- hw/teic_evsense.sv
`timescale 1ns/1ps
`default_nettype none
// edge sensing on one event channel; the input is already synchronous
module teic_evsense (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ev_in,
    output logic rise,
    output logic fall
);
    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = ev_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    assign rise = ev_in & ~prev_r;
    assign fall = ~ev_in & prev_r;
endmodule
`default_nettype wire

//--- sim/teic_ev_model.sv
`timescale 1ns/1ps
`default_nettype none
// routed events and the prescaler tick leave one edge after the request, like a sync stage
module teic_ev_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic a_req,
    input wire logic b_req,
    input wire logic t_req,
    output logic event_a,
    output logic event_b,
    output logic presc_tick
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_a <= 1'h0;
            event_b <= 1'h0;
            presc_tick <= 1'h0;
        end else begin
            event_a <= a_req;
            event_b <= b_req;
            presc_tick <= t_req;
        end
    end
endmodule
`default_nettype wire

//--- sim/teic_properties.sv
`timescale 1ns/1ps
`default_nettype none
module teic_properties #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic event_a,
    input wire logic event_b,
    input wire logic presc_tick,
    input wire logic [15:0] count_value,
    input wire logic [15:0] period_value,
    input wire logic count_dir,
    input wire logic restart_pulse,
    input wire logic update_pulse
);
    logic [7:0] ev_r;
    logic lock_r;
    wire logic wr = psel && penable && pwrite;
    wire logic ctl = wr && paddr == ADDR_W'({teic_pkg::IDX_CTRL, 2'h0});
    wire logic b_dir = ev_r[4] && ev_r[7:5] == 3'h3;
    wire logic a_dir = ev_r[0] && ev_r[3:1] == 3'h3;
    wire logic b_rst = ev_r[4] && ev_r[7:5] inside {3'h4, 3'h5, 3'h6};
    // only the tick may move the counter here
    wire logic plain = !ev_r[0] && !b_rst && presc_tick && !count_dir && !wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_r <= 8'h00;
            lock_r <= 1'h0;
        end else if (wr && paddr == ADDR_W'({teic_pkg::IDX_EVENT_CTRL, 2'h0})) begin
            ev_r <= pwdata[7:0];
        end else if (ctl) begin
            lock_r <= pwdata[0];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_b_rise;
        ev_r[7:4] == 4'h9 && $rose(event_b) |=> restart_pulse;
    endproperty
    a_b_rise: assert property (p_b_rise) else $error("no restart on rise");
    property p_b_any;
        ev_r[7:4] == 4'hB && $changed(event_b) |=> restart_pulse;
    endproperty
    a_b_any: assert property (p_b_any) else $error("no restart on edge");
    property p_b_high;
        ev_r[7:4] == 4'hD && event_b |=> restart_pulse;
    endproperty
    a_b_high: assert property (p_b_high) else $error("no restart while high");
    property p_b_quiet;
        !b_rst && !(ctl && pwdata[2]) |=> !restart_pulse;
    endproperty
    a_b_quiet: assert property (p_b_quiet) else $error("stray restart");
    property p_rst_val;
        restart_pulse |-> count_value == (count_dir ? period_value : 16'h0000);
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("restart value wrong");
    property p_b_dir;
        b_dir |=> count_dir == $past(event_b);
    endproperty
    a_b_dir: assert property (p_b_dir) else $error("b direction wrong");
    property p_a_dir;
        a_dir && !b_dir |=> count_dir == $past(event_a);
    endproperty
    a_a_dir: assert property (p_a_dir) else $error("a direction wrong");
    property p_dir_up;
        !a_dir && !b_dir |=> !count_dir;
    endproperty
    a_dir_up: assert property (p_dir_up) else $error("counting down");
    property p_tick;
        plain && count_value != period_value |=> count_value == $past(count_value) + 16'h0001;
    endproperty
    a_tick: assert property (p_tick) else $error("tick not counted");
    property p_wrap;
        plain && !lock_r && count_value == period_value |=> update_pulse && count_value == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no update at wrap");
    property p_lock;
        lock_r |=> !update_pulse && $stable(period_value);
    endproperty
    a_lock: assert property (p_lock) else $error("update while locked");
    property p_per;
        period_value != $past(period_value) |-> update_pulse;
    endproperty
    a_per: assert property (p_per) else $error("period moved without update");
endmodule

bind teic_top teic_properties #(.ADDR_W(ADDR_W)) i_teic_properties (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .event_a(event_a),
    .event_b(event_b),
    .presc_tick(presc_tick),
    .count_value(count_value),
    .period_value(period_value),
    .count_dir(count_dir),
    .restart_pulse(restart_pulse),
    .update_pulse(update_pulse)
);
`default_nettype wire

//--- sim/teic_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module teic_top_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic event_a, event_b, presc_tick, a_req, b_req, t_req;
    logic count_dir, restart_pulse, update_pulse;
    logic [15:0] count_value, period_value, rv;
    logic [47:0] compare_value;
    logic [7:0] rnd;
    logic [32:0] exp_q[$];
    int failures, checked;
    logic [7:0] a_cfg [5] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07};
    logic [15:0] a_exp [5] = '{16'h0014, 16'h000B, 16'h000E, 16'h0011, 16'h0002};
    logic [7:0] b_cfg [9] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hB0, 8'hD0, 8'hF0, 8'h80};
    logic [15:0] b_mid [9] = '{16'h0102, 16'h0102, 16'h0102, 16'h00FE, 16'h0002, 16'h0002,
        16'h0000, 16'h0102, 16'h0102};
    logic [15:0] b_end [9] = '{16'h0103, 16'h0103, 16'h0103, 16'h00FF, 16'h0003, 16'h0001,
        16'h0001, 16'h0103, 16'h0103};

    teic_top i_teic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_a(event_a), .event_b(event_b), .presc_tick(presc_tick),
        .count_value(count_value), .period_value(period_value), .compare_value(compare_value),
        .count_dir(count_dir), .restart_pulse(restart_pulse), .update_pulse(update_pulse));
    teic_ev_model i_teic_ev_model (.pclk(pclk), .presetn(presetn), .a_req(a_req),
        .b_req(b_req), .t_req(t_req), .event_a(event_a), .event_b(event_b),
        .presc_tick(presc_tick));

    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    task automatic end_sim;
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // {pslverr, prdata} checked at the edge that completes each read
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // idle edge after release so psel never changes twice in one step
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            failures++;
            end_sim();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'h1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'h0, idx, 32'h0000_0000);
    endtask

    task automatic tick;
        t_req <= 1'h1;
        @(posedge pclk);
        t_req <= 1'h0;
        @(posedge pclk);
    endtask

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        a_req = 1'h0;
        b_req = 1'h0;
        t_req = 1'h0;
        failures = 0;
        checked = 0;
        rnd = 8'($urandom(32'h0000_8299));
        rv = 16'($urandom());
        cyc(2);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(teic_pkg::IDX_EVENT_CTRL, 32'h0000_0000);
        rd(teic_pkg::IDX_PER, 32'h0000_FFFF);
        rd(teic_pkg::IDX_FLAGS, 32'h0000_0000);
        rd(8'h01, 33'h1_0000_0000);
        wr(teic_pkg::IDX_EVENT_CTRL, {24'h00_0000, rnd});
        rd(teic_pkg::IDX_EVENT_CTRL, {24'h00_0000, rnd});
        for (int i = 0; i < 5; i++) begin
            wr(teic_pkg::IDX_CNT, 32'h0000_0008);
            wr(teic_pkg::IDX_EVENT_CTRL, {24'h00_0000, a_cfg[i]});
            repeat (3) begin
                a_req <= 1'h1;
                cyc(1);
                repeat (3) tick();
                a_req <= 1'h0;
                cyc(1);
                tick();
            end
            cyc(2);
            rd(teic_pkg::IDX_CNT, {16'h0000, a_exp[i]});
        end
        for (int i = 0; i < 9; i++) begin
            wr(teic_pkg::IDX_CNT, 32'h0000_0100);
            wr(teic_pkg::IDX_EVENT_CTRL, {24'h00_0000, b_cfg[i]});
            b_req <= 1'h1;
            cyc(2);
            repeat (2) tick();
            rd(teic_pkg::IDX_CNT, {16'h0000, b_mid[i]});
            b_req <= 1'h0;
            cyc(2);
            tick();
            cyc(2);
            rd(teic_pkg::IDX_CNT, {16'h0000, b_end[i]});
        end
        wr(teic_pkg::IDX_EVENT_CTRL, 32'h0000_0000);
        wr(teic_pkg::IDX_CTRL, 32'h0000_0001);
        wr(teic_pkg::IDX_PER_BUFFER, 32'h0000_0010);
        wr(teic_pkg::IDX_CMPBUF0, 32'h0000_1234);
        wr(teic_pkg::IDX_CMPBUF0 + (teic_pkg::IDX_CH_STEP << 1), {16'h0000, rv});
        rd(teic_pkg::IDX_FLAGS, 32'h0000_000B);
        wr(teic_pkg::IDX_CTRL, 32'h0000_0003);
        rd(teic_pkg::IDX_FLAGS, 32'h0000_000B);
        rd(teic_pkg::IDX_PER, 32'h0000_FFFF);
        wr(teic_pkg::IDX_CTRL, 32'h0000_0000);
        wr(teic_pkg::IDX_CTRL, 32'h0000_0002);
        rd(teic_pkg::IDX_FLAGS, 32'h0000_0000);
        rd(teic_pkg::IDX_PER, 32'h0000_0010);
        rd(teic_pkg::IDX_CMP0, 32'h0000_1234);
        rd(teic_pkg::IDX_CMP0 + (teic_pkg::IDX_CH_STEP << 1), {16'h0000, rv});
        chk({1'h0, compare_value[47:32], compare_value[15:0]}, {1'h0, rv, 16'h1234});
        wr(teic_pkg::IDX_PER_BUFFER, 32'h0000_0020);
        wr(teic_pkg::IDX_CNT, 32'h0000_000F);
        repeat (2) tick();
        rd(teic_pkg::IDX_FLAGS, 32'h0000_0000);
        rd(teic_pkg::IDX_PER, 32'h0000_0020);
        rd(teic_pkg::IDX_CNT, 32'h0000_0000);
        wr(teic_pkg::IDX_CNT, 32'h0000_0055);
        wr(teic_pkg::IDX_CTRL, 32'h0000_0004);
        rd(teic_pkg::IDX_CNT, 32'h0000_0000);
        rd(teic_pkg::IDX_CTRL, 32'h0000_0000);
        end_sim();
    end
endmodule
`default_nettype wire
